// [uar_pkg.sv]
//
// Behaviour
// [R1] bit recovery oversamples the line at sixteen ticks per bit; shifter advances per bit
// [R2] a complete 8 or 9 bit character moves into a two-entry buffer
// [R3] receiver runs only with receive enable 1, clocked mode 0, port enable 1
// [R4] port enable forces the input pin to input, ignoring its direction bit
// [R5] port enable drives the output pin, ignoring direction and port latch
// [R6] a falling edge on the idle-high line starts a character
// [R7] start bit rechecked at half bit; if high, drop silently and hunt again
// [R8] each later bit is taken one bit time on, by vote, into the shifter
// [R9] stop bit low marks a framing error for that character, high marks none
// [R10] after data and stop, push the character and raise the receive flag
// [R11] reading the data register returns the oldest character and removes it
// [R12] receive flag is high when enabled and a character is unread
// [R13] flag is independent of interrupt enables; interrupt needs all three enables set
// [R14] framing status is stored per character; flag shows the oldest one
// [R15] framing error neither stops reception nor raises an interrupt alone
// [R16] dropping port enable clears framing status; dropping receive enable keeps it
// [R17] third character with buffer full sets overrun and is discarded
// [R18] overrun cleared only by dropping receive or port enable; reception resumes
// [R19] nine-bit select shifts nine bits; ninth bit of oldest character shown
// [R20] software reads ninth bit and framing status before the data register
// [R21] characters arrive least significant bit first into bit zero
// [R22] bit timing comes from the shared baud generator tick
// [R23] vote takes three samples around the bit centre, two of three win
// [R24] reset or port enable low empties buffer, idles recovery, clears flags
//
package uar_pkg;

  // ***********************************************
  // timing and format constants
  // ***********************************************
  localparam int         OVERSAMPLE   = 16;    // ticks per bit
  localparam logic [3:0] VOTE_FIRST   = 4'h7;  // first sample before centre
  localparam logic [3:0] VOTE_LAST    = 4'h9;  // last sample, decision point
  localparam logic [3:0] BITS_EIGHT   = 4'h8;
  localparam logic [3:0] BITS_NINE    = 4'h9;
  localparam logic [1:0] FIFO_DEPTH   = 2'h2;
  localparam int         ENTRY_FRAMING_ERROR_FLAG   = 9;     // framing bit position in an entry
  localparam int         ENTRY_NINTH  = 8;     // ninth data bit position
  localparam logic       IDLE_LEVEL   = 1'b1;

  // ***********************************************
  // state types
  // ***********************************************
  typedef enum logic [3:0] {
    UAR_IDLE  = 4'h1,
    UAR_START = 4'h2,
    UAR_DATA  = 4'h4,
    UAR_STOP  = 4'h8
  } uar_state_t;

  typedef struct packed {
    uar_state_t      st;
    logic [3:0]      tick;
    logic [3:0]      nbits;
    logic [2:0]      vote;
    logic [8:0]      shift;
    logic [1:0]      count;
    logic [1:0][9:0] fifo;
    logic            overrun_error_flag;
    logic            line_q;
  } uar_reg_t;

  localparam uar_reg_t UAR_RESET = '{
    st: UAR_IDLE, tick: 4'h0, nbits: 4'h0, vote: 3'h7, shift: 9'h000,
    count: 2'h0, fifo: 20'h0_0000, overrun_error_flag: 1'b0, line_q: IDLE_LEVEL
  };

endpackage

// [uar_sync3.sv]
`timescale 1ns/1ps
module uar_sync3
  import uar_pkg::*;
#(
  parameter logic RESET_LEVEL = IDLE_LEVEL
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // raw pin and filtered level
  input  wire logic async_in,
  output logic      level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } uar_sync_t;

  uar_sync_t r;
  uar_sync_t next_r;

  // s1 feeds only s2; level moves once s2 and s3 agree
  always_comb begin
    next_r    = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.level = r.s3;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= {4{RESET_LEVEL}};
    end else begin
      r <= next_r;
    end
  end

  assign level_out = r.level;

endmodule

// [uar_rx.sv]
`timescale 1ns/1ps
module uar_rx
  import uar_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // shared baud generator, sixteen ticks per bit
  input  wire logic       baud_tick_in,
  // control bits
  input  wire logic       serial_port_enable_in,
  input  wire logic       continuous_receive_enable_in,
  input  wire logic       clocked_mode_select_in,
  input  wire logic       nine_bit_receive_select_in,
  // interrupt enables
  input  wire logic       receive_irq_enable_in,
  input  wire logic       peripheral_irq_enable_in,
  input  wire logic       global_irq_enable_in,
  // receive data register read strobe
  input  wire logic       data_read_in,
  // serial input pin
  input  wire logic       serial_input_pin_in,
  input  wire logic       input_pin_latch_in,
  input  wire logic       input_pin_direction_in,
  output logic            serial_input_pin_out,
  output logic            serial_input_pin_oe_n_out,
  // serial output pin
  input  wire logic       transmit_serial_in,
  input  wire logic       output_pin_latch_in,
  input  wire logic       output_pin_direction_in,
  output logic            serial_output_pin_out,
  output logic            serial_output_pin_oe_n_out,
  // receive results
  output logic [7:0]      receive_data_out,
  output logic            ninth_received_bit_out,
  output logic            framing_error_flag_out,
  output logic            overrun_error_flag_out,
  output logic            receive_flag_out,
  output logic            irq_out
);

  // ***********************************************
  // declarations
  // ***********************************************
  uar_reg_t   r;
  uar_reg_t   next_r;
  logic       line;
  logic       rx_enable;
  logic       fall;
  logic       decide;
  logic       bit_val;
  logic       pop;
  logic [1:0] cnt_after;
  logic [3:0] width;
  logic [8:0] char_data;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  // ***********************************************
  // pin control
  // ***********************************************
  // port enable overrides direction bits on both pins
  assign serial_input_pin_out       = input_pin_latch_in;
  assign serial_input_pin_oe_n_out  = serial_port_enable_in | input_pin_direction_in;   // [R4]
  assign serial_output_pin_out      = serial_port_enable_in ? transmit_serial_in
                                                            : output_pin_latch_in;      // [R5]
  assign serial_output_pin_oe_n_out = ~serial_port_enable_in & output_pin_direction_in; // [R5]

  // line is filtered, so a one-cycle glitch cannot start a character
  uar_sync3 #(
    .RESET_LEVEL (IDLE_LEVEL)
  ) u_sync (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .async_in  (serial_input_pin_in),
    .level_out (line)
  );

  // ***********************************************
  // receive control
  // ***********************************************
  // the three-bit enable condition
  assign rx_enable = serial_port_enable_in & continuous_receive_enable_in
                   & ~clocked_mode_select_in;                                 // [R3]
  assign fall      = r.line_q & ~line;                                        // [R6]
  assign decide    = baud_tick_in & (r.tick == VOTE_LAST);                    // [R1] [R22]
  assign bit_val   = maj3({r.vote[1:0], line});                               // [R23]
  assign pop       = data_read_in & (r.count != 2'h0);                        // [R11]
  assign width     = nine_bit_receive_select_in ? BITS_NINE : BITS_EIGHT;     // [R19]
  // an eight-bit character sits in the upper shifter bits
  assign char_data = nine_bit_receive_select_in ? r.shift
                                                : {1'b0, r.shift[8:1]};

  // next-state logic for recovery, buffer and flags
  always_comb begin
    next_r    = r;
    cnt_after = r.count;
    if (!serial_port_enable_in) begin
      next_r = UAR_RESET;                                                     // [R24] [R16]
    end else begin
      // read returns the head; the tail moves up and is cleared
      if (pop) begin
        next_r.fifo[0] = r.fifo[1];                                           // [R11] [R14]
        next_r.fifo[1] = 10'h000;
        next_r.count   = r.count - 2'h1;
      end
      cnt_after     = next_r.count;
      next_r.line_q = line;
      if (!rx_enable) begin
        next_r.st = UAR_IDLE;
        if (!continuous_receive_enable_in) begin
          next_r.overrun_error_flag = 1'b0;                                                 // [R18]
        end
      end else begin
        case (r.st)
          UAR_IDLE: begin
            // overrun blocks new characters until it is cleared
            if (fall && !r.overrun_error_flag) begin                                        // [R6] [R17]
              next_r.st    = UAR_START;
              next_r.tick  = 4'h0;
              next_r.nbits = 4'h0;
            end
          end
          default: begin
            if (baud_tick_in) begin
              next_r.tick = r.tick + 4'h1;                                    // [R1]
              if (r.tick >= VOTE_FIRST && r.tick <= VOTE_LAST) begin
                next_r.vote = {r.vote[1:0], line};                            // [R23]
              end
            end
            if (decide) begin
              case (r.st)
                UAR_START: begin
                  // start gone high at its centre: drop with no error
                  if (bit_val) begin
                    next_r.st = UAR_IDLE;                                     // [R7]
                  end else begin
                    next_r.st = UAR_DATA;
                  end
                end
                UAR_DATA: begin
                  next_r.shift = {bit_val, r.shift[8:1]};                     // [R8] [R21]
                  next_r.nbits = r.nbits + 4'h1;
                  if (r.nbits + 4'h1 == width) begin
                    next_r.st = UAR_STOP;                                     // [R2]
                  end
                end
                UAR_STOP: begin
                  next_r.st = UAR_IDLE;
                  if (cnt_after == FIFO_DEPTH) begin
                    next_r.overrun_error_flag = 1'b1;                                       // [R17]
                  end else begin
                    // framing status travels with its character
                    if (cnt_after == 2'h0) begin
                      next_r.fifo[0] = {~bit_val, char_data};                 // [R9] [R14]
                    end else begin
                      next_r.fifo[1] = {~bit_val, char_data};                 // [R9] [R14]
                    end
                    next_r.count = cnt_after + 2'h1;                          // [R10] [R2]
                  end
                end
                default: begin
                  next_r.st = UAR_IDLE;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= UAR_RESET;                                                         // [R24]
    end else begin
      r <= next_r;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  // head entry comes straight from flip-flops; cleared when empty
  assign receive_data_out       = r.fifo[0][7:0];                             // [R11]
  assign ninth_received_bit_out = r.fifo[0][ENTRY_NINTH];                     // [R19]
  assign framing_error_flag_out = r.fifo[0][ENTRY_FRAMING_ERROR_FLAG];                      // [R14]
  assign overrun_error_flag_out = r.overrun_error_flag;                                     // [R17]
  assign receive_flag_out       = rx_enable & (r.count != 2'h0);              // [R12]
  // framing status has no path to the interrupt
  assign irq_out = receive_flag_out & receive_irq_enable_in
                 & peripheral_irq_enable_in & global_irq_enable_in;           // [R13] [R15]

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  start_abort_a: assert property (                                            // [R7]
    serial_port_enable_in && rx_enable && r.st == UAR_START && decide && bit_val && !data_read_in
    |=> r.st == UAR_IDLE && !r.overrun_error_flag && r.count == $past(r.count)
  ) else $error("false start not dropped silently");

  push_flag_a: assert property (                                              // [R10]
    rx_enable && r.st == UAR_STOP && decide && r.count == 2'h0
    |=> r.count == 2'h1 && receive_flag_out
  ) else $error("character not pushed after stop bit");

  framing_error_flag_store_a: assert property (                                             // [R9]
    rx_enable && r.st == UAR_STOP && decide && r.count == 2'h0
    |=> framing_error_flag_out == !$past(bit_val)
  ) else $error("framing status not stored with character");

  overrun_set_a: assert property (                                            // [R17]
    rx_enable && r.st == UAR_STOP && decide && r.count == 2'h2 && !data_read_in
    |=> overrun_error_flag_out && r.count == 2'h2 && $stable(r.fifo)
  ) else $error("overrun not flagged or buffer changed");

  overrun_hold_a: assert property (                                           // [R17]
    r.overrun_error_flag && r.st == UAR_IDLE && serial_port_enable_in |=> r.st == UAR_IDLE
  ) else $error("reception continued during overrun");

  overrun_error_flag_clear_a: assert property (                                             // [R18]
    !continuous_receive_enable_in |=> !overrun_error_flag_out
  ) else $error("overrun not cleared by receive enable low");

  port_reset_a: assert property (                                             // [R24]
    !serial_port_enable_in |=> r.count == 2'h0 && !framing_error_flag_out && r.st == UAR_IDLE
  ) else $error("port enable low did not reset receiver");

  framing_error_flag_keep_a: assert property (                                              // [R16]
    serial_port_enable_in && !continuous_receive_enable_in && !data_read_in
    |=> $stable(framing_error_flag_out)
  ) else $error("framing flag changed by receive enable");

  pop_order_a: assert property (                                              // [R11]
    serial_port_enable_in && data_read_in && r.count == 2'h2 && !(decide && r.st == UAR_STOP)
    |=> receive_data_out == $past(r.fifo[1][7:0]) && r.count == 2'h1
  ) else $error("read did not advance to next character");

  pin_force_a: assert property (                                              // [R4]
    serial_port_enable_in |-> serial_input_pin_oe_n_out && !serial_output_pin_oe_n_out
  ) else $error("pin directions not forced");

  irq_gate_a: assert property (                                               // [R13]
    irq_out |-> receive_flag_out && global_irq_enable_in
  ) else $error("interrupt without flag or enable");

  ninth_bits_a: assert property (                                             // [R19]
    rx_enable && r.st == UAR_DATA && decide && nine_bit_receive_select_in && r.nbits == 4'h7
    |=> r.st == UAR_DATA
  ) else $error("nine-bit character ended early");

  abort_c: cover property (r.st == UAR_START && decide && bit_val);
  push_c: cover property (r.st == UAR_STOP && decide && r.count == 2'h1);
  overrun_c: cover property (!r.overrun_error_flag ##1 r.overrun_error_flag);
  ninth_c: cover property (r.count != 2'h0 && ninth_received_bit_out && framing_error_flag_out);

endmodule

// [uar_line_model.sv]
`timescale 1ns/1ps
// ********************************
// far-end transmitter model
// ********************************
module uar_line_model (
  // clock and baud tick
  input  wire logic clk_in,
  input  wire logic baud_tick_in,
  // serial line
  output logic      line_out
);
  // the line idles at mark; each move after the first of a frame or glitch happens just after a baud tick edge
  initial line_out = 1'b1;

  // bit timing comes from the same tick the receiver uses
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_in);
      while (!baud_tick_in) @(posedge clk_in);
    end
  endtask

  // one frame: start, data lsb first, stop at the asked level, short idle
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    line_out <= 1'b0;
    ticks(16);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      ticks(16);
    end
    line_out <= stop;
    ticks(16);
    line_out <= 1'b1;
    ticks(4);
  endtask

  // low pulse that is gone well before the start-bit centre
  task automatic glitch();
    line_out <= 1'b0;
    ticks(4);
    line_out <= 1'b1;
    ticks(24);
  endtask
endmodule

// [uar_rx_tb.sv]
`timescale 1ns/1ps
module uar_rx_tb;
  import uar_pkg::*;
  // ********************************
  // stimulus and observed signals
  // ********************************
  logic       clk_in, reset_in, tick, pe, continuous_receive_enable, clkm, nine, rie, pie, global_irq_enable, rd, line;
  logic       in_latch, in_dir, tx, out_latch, out_dir;
  logic [1:0] tdiv;
  logic [7:0] data;
  logic       ninth, framing_error_flag, overrun_error_flag, flag, irq, in_o, in_oe_n, out_o, out_oe_n;
  int         fail_count, n_compared;

  uar_line_model line_u (.clk_in(clk_in), .baud_tick_in(tick), .line_out(line));

  uar_rx dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .baud_tick_in(tick),
    .serial_port_enable_in(pe), .continuous_receive_enable_in(continuous_receive_enable),
    .clocked_mode_select_in(clkm), .nine_bit_receive_select_in(nine),
    .receive_irq_enable_in(rie), .peripheral_irq_enable_in(pie), .global_irq_enable_in(global_irq_enable),
    .data_read_in(rd), .serial_input_pin_in(line), .input_pin_latch_in(in_latch),
    .input_pin_direction_in(in_dir), .serial_input_pin_out(in_o), .serial_input_pin_oe_n_out(in_oe_n),
    .transmit_serial_in(tx), .output_pin_latch_in(out_latch), .output_pin_direction_in(out_dir),
    .serial_output_pin_out(out_o), .serial_output_pin_oe_n_out(out_oe_n),
    .receive_data_out(data), .ninth_received_bit_out(ninth), .framing_error_flag_out(framing_error_flag),
    .overrun_error_flag_out(overrun_error_flag), .receive_flag_out(flag), .irq_out(irq)
  );

  // 5 ns clock; a baud tick every fourth cycle keeps frames short
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // plain always: the stimulus block also gives tdiv and tick their start values
  always @(posedge clk_in) begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // land past the edge so flop updates are settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // status fields first, since the read strobe moves all three on
  task automatic rd_char(input logic [8:0] d, input logic fe);
    step(1);
    check({8'h00, ninth}, {8'h00, d[8]});
    check({8'h00, framing_error_flag}, {8'h00, fe});
    check({1'b0, data}, {1'b0, d[7:0]});
    @(posedge clk_in);
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well beyond the roughly 28 us the sequence needs
  initial begin
    #200_000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {reset_in, pe, continuous_receive_enable, rie, pie, tx, out_dir} = 7'h7F;
    {clkm, nine, global_irq_enable, rd, in_latch, in_dir, out_latch, tdiv, tick} = 10'h000;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    step(2);
    check({irq, flag, overrun_error_flag, framing_error_flag, ninth, 4'h0}, 9'h000);
    check({5'h00, in_oe_n, out_o, out_oe_n, 1'b0}, 9'h00C);
    // framing error, then a good one, then a third with the buffer full
    line_u.send(9'h0A5, 8, 1'b0);
    step(8);
    check({7'h00, flag, irq}, 9'h002);
    @(posedge clk_in);
    global_irq_enable <= 1'b1;
    step(1);
    check({8'h00, irq}, 9'h001);
    line_u.send(9'h03C, 8, 1'b1);
    line_u.send(9'h05A, 8, 1'b1);
    step(8);
    check({8'h00, overrun_error_flag}, 9'h001);
    rd_char(9'h0A5, 1'b1);
    rd_char(9'h03C, 1'b0);
    step(2);
    check({flag, data}, 9'h000);
    // overrun still set: nothing new is taken
    line_u.send(9'h066, 8, 1'b1);
    step(8);
    check({flag, data}, 9'h000);
    @(posedge clk_in);
    continuous_receive_enable <= 1'b0;
    step(2);
    check({8'h00, overrun_error_flag}, 9'h000);
    @(posedge clk_in);
    continuous_receive_enable <= 1'b1;
    line_u.glitch();
    step(8);
    check({8'h00, flag}, 9'h000);
    line_u.send(9'h081, 8, 1'b1);
    step(8);
    check({flag, data}, 9'h181);
    // disabled receiver hides the character but keeps it
    @(posedge clk_in);
    continuous_receive_enable <= 1'b0;
    step(2);
    check({8'h00, flag}, 9'h000);
    @(posedge clk_in);
    continuous_receive_enable <= 1'b1;
    step(2);
    check({8'h00, flag}, 9'h001);
    rd_char(9'h081, 1'b0);
    // nine-bit characters
    @(posedge clk_in);
    nine <= 1'b1;
    line_u.send(9'h1C3, 9, 1'b1);
    line_u.send(9'h0FE, 9, 1'b0);
    rd_char(9'h1C3, 1'b0);
    @(posedge clk_in);
    continuous_receive_enable <= 1'b0;
    step(2);
    check({8'h00, framing_error_flag}, 9'h001);
    // port enable low resets the unit and hands the pins back
    @(posedge clk_in);
    pe <= 1'b0;
    continuous_receive_enable <= 1'b1;
    step(2);
    check({framing_error_flag, flag, data[6:0]}, 9'h000);
    check({5'h00, in_oe_n, out_o, out_oe_n, 1'b0}, 9'h002);
    @(posedge clk_in);
    pe <= 1'b1;
    nine <= 1'b0;
    clkm <= 1'b1;
    line_u.send(9'h0A5, 8, 1'b1);
    step(8);
    check({8'h00, flag}, 9'h000);
    give_verdict();
  end
endmodule
